// ==== hw/rsl_ref_select.sv ====
// Reference source selection, loss monitors and loop dividers
// What this block does
// - Selection 00 forces input A as loop reference, never switching.
// - Selection 01 forces input B as loop reference, never switching.
// - Mode 11 uses A whenever A is active, otherwise B.
// - Entering mode 10 starts on input A; mode 11 picks B at once if A is absent.
// - Non-revertive mode changes source only when the current one fails.
// - Automatic decisions look only at the two absence detector states.
// - Absent pins are valid only in modes 10 and 11.
// - One two-bit timeout sets 1, 3.0, 13 or 32 MHz minimum frequency.
// - Pin format: 00 reserved, 01 NMOS drain, 10 PMOS drain, 11 CMOS.
// - Reference and feedback dividers are 12 bits, 1 to 4095, zero invalid.
module rsl_ref_select #(
  parameter int DIVW = rsl_pkg::DIV_WIDTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ref_input_a_i,
  input  wire logic        ref_input_b_i,
  input  wire logic        fb_clk_i,
  output logic             ref_sel_clk_o,
  output logic             ref_sel_b_o,
  output logic             pd_ref_o,
  output logic             pd_fb_o,
  output logic             ref_a_absent_flag_o,
  output logic             ref_a_absent_flag_oe_o,
  output logic             ref_b_absent_flag_o,
  output logic             ref_b_absent_flag_oe_o,
  output logic             irq_o
);

  // ==========================================================
  // Declarations
  logic [1:0]            ref_source_select;
  logic [1:0]            absence_timeout_sel;
  logic [1:0]            absent_pin_format;
  logic [DIVW-1:0]       loop1_ref_div;
  logic [DIVW-1:0]       loop1_feedback_div;
  logic [2:0]            irq_status;
  logic [2:0]            irq_mask;
  logic [2:0]            sync1;
  logic [2:0]            sync2;
  logic [2:0]            sync3;
  logic [2:0]            rise;
  logic [7:0]            idle_cnt [2];
  logic [1:0]            signal_absent_flag;
  logic [1:0]            absent_prev;
  logic [7:0]            tmo_limit;
  logic                  is_auto;
  logic                  was_auto;
  logic [1:0]            prev_mode;
  rsl_pkg::rsl_sel_state_t sel_state;
  rsl_pkg::rsl_sel_state_t next_sel_state;
  logic                  want_b;
  logic                  quiet;
  logic                  switched;
  logic                  wb_req;
  logic                  wr_en;
  logic [31:0]           rd_word;
  logic [31:0]           wr_word;

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = data[i*8 +: 8];
    return r;
  endfunction

  // Timeout window in clock cycles for a timeout setting
  function automatic logic [7:0] tmo_cycles(input logic [1:0] s);
    case (s)
      2'h0:    return rsl_pkg::TMO_CYC0;
      2'h1:    return rsl_pkg::TMO_CYC1;
      2'h2:    return rsl_pkg::TMO_CYC2;
      default: return rsl_pkg::TMO_CYC3;
    endcase
  endfunction

  // ==========================================================
  // Wishbone slave
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_en  = wb_req && wb_we_i && !wb_ack_o;
  assign wr_word = merge(rd_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req && !wb_ack_o;
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      rsl_pkg::ADDR_CONFIG:
      begin
        rd_word[rsl_pkg::CFG_SEL_LSB +: 2] = ref_source_select;
        rd_word[rsl_pkg::CFG_TMO_LSB +: 2] = absence_timeout_sel;
        rd_word[rsl_pkg::CFG_FMT_LSB +: 2] = absent_pin_format;
      end
      rsl_pkg::ADDR_DIVIDE:
      begin
        rd_word[rsl_pkg::DIV_REF_LSB +: DIVW] = loop1_ref_div;
        rd_word[rsl_pkg::DIV_FB_LSB +: DIVW]  = loop1_feedback_div;
      end
      rsl_pkg::ADDR_STATUS:
      begin
        rd_word[rsl_pkg::ST_SEL_B_BIT] = ref_sel_b_o;
        rd_word[rsl_pkg::ST_ABS_A_BIT] = signal_absent_flag[0];
        rd_word[rsl_pkg::ST_ABS_B_BIT] = signal_absent_flag[1];
      end
      rsl_pkg::ADDR_IRQ_ST:  rd_word[2:0] = irq_status;
      rsl_pkg::ADDR_IRQ_MSK: rd_word[2:0] = irq_mask;
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_ack_o)
      wb_dat_o <= rd_word;
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_source_select   <= rsl_pkg::RST_SEL;
      absence_timeout_sel <= rsl_pkg::RST_TMO;
      absent_pin_format   <= rsl_pkg::RST_FMT;
    end
    else if (wr_en && wb_adr_i == rsl_pkg::ADDR_CONFIG)
    begin
      ref_source_select   <= wr_word[1:0];
      absence_timeout_sel <= wr_word[3:2];
      absent_pin_format   <= wr_word[5:4];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loop1_ref_div      <= rsl_pkg::RST_DIV;
      loop1_feedback_div <= rsl_pkg::RST_DIV;
    end
    else if (wr_en && wb_adr_i == rsl_pkg::ADDR_DIVIDE)
    begin
      loop1_ref_div      <= wr_word[11:0];
      loop1_feedback_div <= wr_word[27:16];
    end
  end

  // ==========================================================
  // Pin synchronisers and rising edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end
    else
    begin
      sync1 <= {fb_clk_i, ref_input_b_i, ref_input_a_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;

  // ==========================================================
  // Absence detectors, one timeout for both inputs
  assign tmo_limit = tmo_cycles(absence_timeout_sel);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idle_cnt[0]        <= 8'h00;
      idle_cnt[1]        <= 8'h00;
      signal_absent_flag <= 2'h3;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rise[i])
        begin
          idle_cnt[i]           <= 8'h00;
          signal_absent_flag[i] <= 1'b0;
        end
        else if (idle_cnt[i] >= tmo_limit)
          signal_absent_flag[i] <= 1'b1;
        else
          idle_cnt[i] <= idle_cnt[i] + 8'h01;
      end
    end
  end

  // ==========================================================
  // Source selection
  assign is_auto = ref_source_select[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      was_auto  <= 1'b0;
      prev_mode <= rsl_pkg::RST_SEL;
    end
    else
    begin
      was_auto  <= is_auto;
      prev_mode <= ref_source_select;
    end
  end

  always_comb
  begin
    next_sel_state = sel_state;
    if (!is_auto || !was_auto || prev_mode != ref_source_select)
      next_sel_state = rsl_pkg::ST_USE_A;
    else
      case (sel_state)
        rsl_pkg::ST_USE_A:
          if (signal_absent_flag[0] && !signal_absent_flag[1])
            next_sel_state = rsl_pkg::ST_USE_B;
        rsl_pkg::ST_USE_B:
          if (signal_absent_flag[1] && !signal_absent_flag[0])
            next_sel_state = rsl_pkg::ST_USE_A;
        default: next_sel_state = rsl_pkg::ST_USE_A;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel_state <= rsl_pkg::ST_USE_A;
    else
      sel_state <= next_sel_state;
  end

  always_comb
  begin
    case (ref_source_select)
      rsl_pkg::SEL_FORCE_A: want_b = 1'b0;
      rsl_pkg::SEL_FORCE_B: want_b = 1'b1;
      rsl_pkg::SEL_NONREV:  want_b = (sel_state == rsl_pkg::ST_USE_B);
      rsl_pkg::SEL_REVERT:  want_b = signal_absent_flag[0];
      default:              want_b = 1'b0;
    endcase
  end

  // ==========================================================
  // Glitch-free reference mux
  assign quiet = !sync2[0] && !sync2[1];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_sel_b_o   <= 1'b0;
      ref_sel_clk_o <= 1'b0;
      switched      <= 1'b0;
    end
    else
    begin
      switched <= quiet && (want_b != ref_sel_b_o);
      if (quiet)
        ref_sel_b_o <= want_b;
      ref_sel_clk_o <= ref_sel_b_o ? sync2[1] : sync2[0];
    end
  end

  // ==========================================================
  // Loop dividers
  rsl_divider #(.WIDTH(DIVW)) u_ref_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (ref_sel_b_o ? rise[1] : rise[0]),
    .div_i   (loop1_ref_div),
    .pulse_o (pd_ref_o)
  );

  rsl_divider #(.WIDTH(DIVW)) u_fb_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (rise[2]),
    .div_i   (loop1_feedback_div),
    .pulse_o (pd_fb_o)
  );

  // ==========================================================
  // Absent status pins
  always_comb
  begin
    ref_a_absent_flag_o    = 1'b0;
    ref_a_absent_flag_oe_o = 1'b0;
    ref_b_absent_flag_o    = 1'b0;
    ref_b_absent_flag_oe_o = 1'b0;
    if (is_auto)
      case (absent_pin_format)
        rsl_pkg::FMT_NMOS_OD:
        begin
          ref_a_absent_flag_oe_o = !signal_absent_flag[0];
          ref_b_absent_flag_oe_o = !signal_absent_flag[1];
        end
        rsl_pkg::FMT_PMOS_OD:
        begin
          ref_a_absent_flag_o    = 1'b1;
          ref_b_absent_flag_o    = 1'b1;
          ref_a_absent_flag_oe_o = signal_absent_flag[0];
          ref_b_absent_flag_oe_o = signal_absent_flag[1];
        end
        rsl_pkg::FMT_CMOS:
        begin
          ref_a_absent_flag_o    = signal_absent_flag[0];
          ref_b_absent_flag_o    = signal_absent_flag[1];
          ref_a_absent_flag_oe_o = 1'b1;
          ref_b_absent_flag_oe_o = 1'b1;
        end
        default:
        begin
          ref_a_absent_flag_oe_o = 1'b0;
          ref_b_absent_flag_oe_o = 1'b0;
        end
      endcase
  end

  // ==========================================================
  // Interrupts: sticky status, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      absent_prev <= 2'h3;
    else
      absent_prev <= signal_absent_flag;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status <= 3'h0;
    else
    begin
      for (int i = 0; i < rsl_pkg::IRQ_WIDTH; i++)
        if (wr_en && wb_adr_i == rsl_pkg::ADDR_IRQ_ST && wb_sel_i[0]
            && wb_dat_i[i])
          irq_status[i] <= 1'b0;
      if (switched)
        irq_status[rsl_pkg::IRQ_SWITCH] <= 1'b1;
      if (signal_absent_flag[0] && !absent_prev[0])
        irq_status[rsl_pkg::IRQ_LOST_A] <= 1'b1;
      if (signal_absent_flag[1] && !absent_prev[1])
        irq_status[rsl_pkg::IRQ_LOST_B] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= rsl_pkg::RST_IRQ_MSK;
    else if (wr_en && wb_adr_i == rsl_pkg::ADDR_IRQ_MSK && wb_sel_i[0])
      irq_mask <= wb_dat_i[2:0];
  end

  assign irq_o = |(irq_status & irq_mask);

  // ==========================================================
  // Checks
  a_forced_a_used: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ref_source_select == rsl_pkg::SEL_FORCE_A && quiet) |=> !ref_sel_b_o)
    else $error("forced A mode did not select input A");

  a_forced_b_used: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ref_source_select == rsl_pkg::SEL_FORCE_B && quiet) |=> ref_sel_b_o)
    else $error("forced B mode did not select input B");

  a_nonrev_to_b: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sel_state == rsl_pkg::ST_USE_A && is_auto && was_auto
     && $stable(ref_source_select) && !ref_source_select[0]
     && signal_absent_flag == 2'b01) |=> sel_state == rsl_pkg::ST_USE_B)
    else $error("non-revertive mode did not move to input B");

  a_revert_prefers_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ref_source_select == rsl_pkg::SEL_REVERT)
    |-> want_b == signal_absent_flag[0])
    else $error("revertive choice does not follow input A state");

  a_auto_entry_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (is_auto && !was_auto) |=> sel_state == rsl_pkg::ST_USE_A)
    else $error("automatic mode did not start on input A");

  a_nonrev_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (is_auto && was_auto && $stable(ref_source_select)
     && sel_state == rsl_pkg::ST_USE_B && !signal_absent_flag[1])
    |=> sel_state == rsl_pkg::ST_USE_B)
    else $error("non-revertive mode left a healthy input");

  a_pins_forced_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_auto |-> !ref_a_absent_flag_oe_o && !ref_b_absent_flag_oe_o)
    else $error("absent pins driven in a forced mode");

  a_cmos_pin_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (is_auto && absent_pin_format == rsl_pkg::FMT_CMOS)
    |-> ref_a_absent_flag_oe_o
        && ref_a_absent_flag_o == signal_absent_flag[0])
    else $error("CMOS absent pin does not show the detector");

  a_loss_timeout: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!rise[0] && idle_cnt[0] >= tmo_limit) |=> signal_absent_flag[0])
    else $error("input A not flagged after the timeout");

  a_switch_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $changed(ref_sel_b_o) |-> $past(quiet))
    else $error("source changed while an input was high");

  c_nonrev_switch: cover property (@(posedge clk_i) disable iff (rst_i)
    ref_source_select == rsl_pkg::SEL_NONREV && $rose(ref_sel_b_o));
  c_revert_back: cover property (@(posedge clk_i) disable iff (rst_i)
    ref_source_select == rsl_pkg::SEL_REVERT && $fell(ref_sel_b_o));
  c_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(irq_o));

endmodule // rsl_ref_select

// ==== hw/rsl_pkg.sv ====
// Shared constants for the reference select and loss monitor block
package rsl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_DIVIDE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_TMO_LSB  = 2;
  localparam int CFG_FMT_LSB  = 4;
  localparam int DIV_REF_LSB  = 0;
  localparam int DIV_FB_LSB   = 16;
  localparam int DIV_WIDTH    = 12;
  localparam int ST_SEL_B_BIT = 0;
  localparam int ST_ABS_A_BIT = 1;
  localparam int ST_ABS_B_BIT = 2;
  localparam int IRQ_SWITCH   = 0;
  localparam int IRQ_LOST_A   = 1;
  localparam int IRQ_LOST_B   = 2;
  localparam int IRQ_WIDTH    = 3;

  // ==========================================================
  // Reset values
  localparam logic [1:0]  RST_SEL    = 2'h0;
  localparam logic [1:0]  RST_TMO    = 2'h0;
  localparam logic [1:0]  RST_FMT    = 2'h0;
  localparam logic [11:0] RST_DIV    = 12'h001;
  localparam logic [2:0]  RST_IRQ_MSK = 3'h0;

  // ==========================================================
  // Source selection modes
  localparam logic [1:0] SEL_FORCE_A = 2'h0;
  localparam logic [1:0] SEL_FORCE_B = 2'h1;
  localparam logic [1:0] SEL_NONREV  = 2'h2;
  localparam logic [1:0] SEL_REVERT  = 2'h3;

  // Absent pin formats
  localparam logic [1:0] FMT_RESERVED = 2'h0;
  localparam logic [1:0] FMT_NMOS_OD  = 2'h1;
  localparam logic [1:0] FMT_PMOS_OD  = 2'h2;
  localparam logic [1:0] FMT_CMOS     = 2'h3;

  // ==========================================================
  // Timing: clock rate and minimum detectable frequencies in kHz
  localparam int CLK_FREQ_KHZ  = 20000;
  localparam int MIN_FREQ0_KHZ = 1000;
  localparam int MIN_FREQ1_KHZ = 3000;
  localparam int MIN_FREQ2_KHZ = 13000;
  localparam int MIN_FREQ3_KHZ = 32000;
  localparam int LOS_PERIODS   = 2;
  localparam int TMO_WIDTH     = 8;

  // One slowest period in clock cycles, rounded up, at least one
  function automatic int period_cycles(input int f_khz);
    int c;
    c = (CLK_FREQ_KHZ + f_khz - 1) / f_khz;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] TMO_CYC0 = 8'(LOS_PERIODS * period_cycles(MIN_FREQ0_KHZ));
  localparam logic [7:0] TMO_CYC1 = 8'(LOS_PERIODS * period_cycles(MIN_FREQ1_KHZ));
  localparam logic [7:0] TMO_CYC2 = 8'(LOS_PERIODS * period_cycles(MIN_FREQ2_KHZ));
  localparam logic [7:0] TMO_CYC3 = 8'(LOS_PERIODS * period_cycles(MIN_FREQ3_KHZ));

  // Selection state, one-hot
  typedef enum logic [1:0] {
    ST_USE_A = 2'b01,
    ST_USE_B = 2'b10
  } rsl_sel_state_t;

endpackage

// ==== hw/rsl_divider.sv ====
// Programmable edge divider for the loop reference and feedback paths
module rsl_divider #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic [WIDTH-1:0] div_i,
  output logic                  pulse_o
);

  logic [WIDTH-1:0] count;

  // ==========================================================
  // Count input edges, one pulse every div_i edges; zero stalls
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count   <= '0;
      pulse_o <= 1'b0;
    end
    else if (tick_i && div_i != '0)
    begin
      if (count + WIDTH'(1) >= div_i)
      begin
        count   <= '0;
        pulse_o <= 1'b1;
      end
      else
      begin
        count   <= count + WIDTH'(1);
        pulse_o <= 1'b0;
      end
    end
    else
    begin
      pulse_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_zero_div_silent: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (div_i == '0) |=> !pulse_o)
    else $error("divider pulsed with a zero divide value");

endmodule // rsl_divider

// ==== bench/rsl_ref_src.sv ====
// Behavioural reference clock source for the selector
module rsl_ref_src #(
  parameter int HALF_NS = 125
) (
  input  wire logic run_i,
  output logic      clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Toggles while running, stands low while stopped
  initial
  begin
    clk_o = 1'b0;
    #7;
    forever
    begin
      #HALF_NS;
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
endmodule // rsl_ref_src

// ==== bench/testbench.sv ====
// Self-checking bench for the reference selector
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rsp;
  logic        ack;
  logic        run_a = 1'b0;
  logic        run_b = 1'b0;
  logic        run_f = 1'b0;
  logic        ra, rb, fb, sclk, sel_b, pref, pfb;
  logic        ao, aoe, bo, boe, irq;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  // ==========================================================
  // Design and far-side sources
  rsl_ref_select uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ref_input_a_i(ra),
    .ref_input_b_i(rb), .fb_clk_i(fb), .ref_sel_clk_o(sclk),
    .ref_sel_b_o(sel_b), .pd_ref_o(pref), .pd_fb_o(pfb),
    .ref_a_absent_flag_o(ao), .ref_a_absent_flag_oe_o(aoe),
    .ref_b_absent_flag_o(bo), .ref_b_absent_flag_oe_o(boe),
    .irq_o(irq)
  );
  rsl_ref_src #(.HALF_NS(125)) src_a (.run_i(run_a), .clk_o(ra));
  rsl_ref_src #(.HALF_NS(115)) src_b (.run_i(run_b), .clk_o(rb));
  rsl_ref_src #(.HALF_NS(125)) src_f (.run_i(run_f), .clk_o(fb));
  // ==========================================================
  // Clock, timeout and helpers
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rsp = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
      check(32'h0, 32'h1);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rsp, e);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] s, t, f);
    return {26'h0, f, t, s};
  endfunction
  task automatic wait_sel(input logic v);
    int n;
    n = 0;
    while (sel_b !== v && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    check(sel_b, v);
  endtask
  task automatic gap(input logic f, input int exp);
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end while ((f ? pfb : pref) !== 1'b1 && n < 25000);
    end
    check(n, exp);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(rsl_pkg::ADDR_CONFIG, 32'h0);
    rd(rsl_pkg::ADDR_DIVIDE, 32'h0001_0001);
    rd(rsl_pkg::ADDR_STATUS, 32'h6);
    rd(rsl_pkg::ADDR_IRQ_MSK, 32'h0);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
  endtask
  task automatic t_forced();
    wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h1, 2'h1, 2'h0));
    wait_sel(1'b1);
    run_b <= 1'b0;
    idle(60);
    check(sel_b, 1'b1);
    wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h0, 2'h1, 2'h3));
    wait_sel(1'b0);
    run_a <= 1'b0;
    run_b <= 1'b1;
    idle(60);
    check(sel_b, 1'b0);
    check({ao, aoe, bo, boe}, 4'h0);
  endtask
  task automatic t_nonrev();
    run_a <= 1'b1;
    idle(20);
    wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h2, 2'h1, 2'h3));
    wb(1'b1, rsl_pkg::ADDR_IRQ_ST, 32'h7);
    wb(1'b1, rsl_pkg::ADDR_IRQ_MSK, 32'h0);
    check(sel_b, 1'b0);
    run_a <= 1'b0;
    wait_sel(1'b1);
    check({ao, aoe, bo, boe}, 4'hd);
    rd(rsl_pkg::ADDR_STATUS, 32'h3);
    rd(rsl_pkg::ADDR_IRQ_ST, 32'h3);
    check(irq, 1'b0);
    wb(1'b1, rsl_pkg::ADDR_IRQ_MSK, 32'h2);
    check(irq, 1'b1);
    wb(1'b1, rsl_pkg::ADDR_IRQ_ST, 32'h3);
    check(irq, 1'b0);
    rd(rsl_pkg::ADDR_IRQ_ST, 32'h0);
    run_a <= 1'b1;
    idle(60);
    check(sel_b, 1'b1);
    check(ao, 1'b0);
    run_b <= 1'b0;
    wait_sel(1'b0);
    run_b <= 1'b1;
  endtask
  task automatic t_revert();
    logic [3:0] pins [4] = '{4'h0, 4'h1, 4'he, 4'hd};
    idle(20);
    wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h3, 2'h1, 2'h0));
    wait_sel(1'b0);
    run_a <= 1'b0;
    wait_sel(1'b1);
    for (int f = 0; f < 4; f++)
    begin
      wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h3, 2'h1, 2'(f)));
      check({ao, aoe, bo, boe}, pins[f]);
    end
    run_a <= 1'b1;
    wait_sel(1'b0);
  endtask
  task automatic t_timeout();
    int lo [4] = '{30, 8, 0, 0};
    int hi [4] = '{50, 26, 14, 14};
    for (int t = 0; t < 4; t++)
    begin
      run_a <= 1'b1;
      wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h2, 2'(t), 2'h3));
      idle(20);
      run_a <= 1'b0;
      idle(lo[t]);
      if (lo[t] > 0)
        check(ao, 1'b0);
      idle(hi[t] - lo[t]);
      check(ao, 1'b1);
    end
  endtask
  task automatic t_div();
    int   n;
    int   r;
    logic last;
    run_a <= 1'b1;
    wb(1'b1, rsl_pkg::ADDR_CONFIG, cfg(2'h0, 2'h0, 2'h0));
    wb(1'b1, rsl_pkg::ADDR_DIVIDE, {4'h0, 12'hfff, 4'h0, 12'h001});
    gap(1'b0, 5);
    gap(1'b1, 20475);
    wb(1'b1, rsl_pkg::ADDR_DIVIDE, {4'h0, 12'h000, 4'h0, 12'h003});
    gap(1'b0, 15);
    n = 0;
    r = 0;
    last = sclk;
    repeat (100)
    begin
      @(posedge clk_i);
      if (pfb === 1'b1)
        n++;
      if (sclk === 1'b1 && last === 1'b0)
        r++;
      last = sclk;
    end
    check(n, 0);
    check(r, 20);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    idle(3);
    rst_i <= 1'b0;
    t_reset();
    run_a <= 1'b1;
    run_b <= 1'b1;
    run_f <= 1'b1;
    t_forced();
    t_nonrev();
    t_revert();
    t_timeout();
    t_div();
    test_done();
  end
endmodule // testbench
